// ==== inc/lmc_pkg.sv ====
package lmc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned BLANK_MS        = 150;
  localparam int unsigned CLOSE_LIMIT_MS  = 1000;
  localparam int unsigned FILTER_US       = 100;
  localparam int unsigned BLANK_CYC       = (CLK_HZ / 1000) * BLANK_MS;
  localparam int unsigned CLOSE_LIMIT_CYC = (CLK_HZ / 1000) * CLOSE_LIMIT_MS;
  localparam int unsigned FILTER_CYC      = (CLK_HZ / 1_000_000) * FILTER_US;
  // ----------------------------------------
  // PWM
  // ----------------------------------------
  localparam int unsigned PWM_W        = 8;
  localparam logic [7:0]  DUTY_RESET   = 8'h80;
  localparam logic [7:0]  DUTY_MIN     = 8'h10;
  localparam logic [7:0]  DUTY_MAX     = 8'hFF;
  localparam int unsigned DUTY_STEP_US = 100;
  localparam int unsigned DUTY_STEP_CYC = (CLK_HZ / 1_000_000) * DUTY_STEP_US;
  // ----------------------------------------
  // Motor states
  // ----------------------------------------
  typedef enum logic [1:0] {
    LMC_IDLE  = 2'b00,
    LMC_BLANK = 2'b01,
    LMC_RUN   = 2'b11,
    LMC_STALL = 2'b10
  } lmc_state_t;
endpackage : lmc_pkg

// ==== inc/lmc_pwm_if.sv ====
`timescale 1ns/1ps
interface lmc_pwm_if;
  logic       enable;
  logic       volt_low;
  logic       volt_high;
  logic       pwm;
  logic [7:0] duty;
  modport ctrl (output enable, output volt_low, output volt_high, input pwm, input duty);
  modport gen  (input enable, input volt_low, input volt_high, output pwm, output duty);
endinterface : lmc_pwm_if

// ==== rtl/lmc_pwm.sv ====
`timescale 1ns/1ps
module lmc_pwm (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  lmc_pwm_if.gen    pif
);
  // ----------------------------------------
  // Duty adjust and carrier
  // ----------------------------------------
  logic [7:0]  duty_r, duty_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [15:0] step_r, step_nxt;
  logic        pwm_r, pwm_nxt;
  logic        tick;

  assign tick = (step_r == 16'(lmc_pkg::DUTY_STEP_CYC - 1));

  always_comb begin
    step_nxt = tick ? 16'h0000 : step_r + 16'h0001;
    duty_nxt = duty_r;
    if (tick && pif.volt_low && duty_r != lmc_pkg::DUTY_MAX) begin
      duty_nxt = duty_r + 8'h01;
    end else if (tick && pif.volt_high && duty_r != lmc_pkg::DUTY_MIN) begin
      duty_nxt = duty_r - 8'h01;
    end
    cnt_nxt = cnt_r + 8'h01;
    pwm_nxt = pif.enable && (cnt_r < duty_r);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duty_r <= lmc_pkg::DUTY_RESET;
      cnt_r  <= 8'h00;
      step_r <= 16'h0000;
      pwm_r  <= 1'b0;
    end else begin
      duty_r <= duty_nxt;
      cnt_r  <= cnt_nxt;
      step_r <= step_nxt;
      pwm_r  <= pwm_nxt;
    end
  end

  assign pif.pwm  = pwm_r;
  assign pif.duty = duty_r;

  a_duty_bounds: assert property (@(posedge clk) disable iff (!rst_n)
    duty_r >= lmc_pkg::DUTY_MIN) else $error("duty below minimum");
  a_pwm_off: assert property (@(posedge clk) disable iff (!rst_n)
    !pif.enable |=> !pwm_r) else $error("pwm while disabled");
endmodule : lmc_pwm

// ==== rtl/lmc_lock_motor_controller.sv ====
// Operation
// - Falling command edge selects open, rising edge selects close.
// - Either command edge, rising or falling, starts the motor.
// - Over-current ignored during blanking interval after each start.
// - After blanking, over-current stops the motor at once.
// - Over-current input is delay-filtered against spikes and noise.
// - Command change while running reverses direction.
// - Closing time runs from switch-on to current switch-off while closing.
// - Error output goes high when closing time is below the limit.
// - Error output stays high until next falling command edge.
// - PWM duty follows voltage-error integrator up and down signals.
`timescale 1ns/1ps
module lmc_lock_motor_controller #(
  parameter int unsigned BLANK_CYC       = lmc_pkg::BLANK_CYC,
  parameter int unsigned CLOSE_LIMIT_CYC = lmc_pkg::CLOSE_LIMIT_CYC,
  parameter int unsigned FILTER_CYC      = lmc_pkg::FILTER_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pins in
  input  wire logic lock_command_input,
  input  wire logic overcurrent_compare,
  input  wire logic volt_low,
  input  wire logic volt_high,
  // Bridge and status
  output logic      bridge_open,
  output logic      bridge_close,
  output logic      error_out,
  output logic      motor_on,
  output logic      direction_close
);
  if (BLANK_CYC < 1 || CLOSE_LIMIT_CYC < 1 || FILTER_CYC < 1 ||
      BLANK_CYC >= 2**26 || CLOSE_LIMIT_CYC >= 2**26 || FILTER_CYC >= 2**26) begin : g_bad_timing
    $error("timing parameter out of range");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic [1:0] prime_r, prime_nxt;
  logic       cmd_d_r, cmd_d_nxt;
  logic       cmd, oc_raw, vlo, vhi, rise, fall, primed;

  always_comb begin
    s1_nxt    = {volt_high, volt_low, overcurrent_compare, lock_command_input};
    s2_nxt    = s1_r;
    cmd_d_nxt = s2_r[0];
    prime_nxt = primed ? prime_r : prime_r + 2'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r    <= 4'h0;
      s2_r    <= 4'h0;
      cmd_d_r <= 1'b0;
      prime_r <= 2'h0;
    end else begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      cmd_d_r <= cmd_d_nxt;
      prime_r <= prime_nxt;
    end
  end

  assign cmd    = s2_r[0];
  assign oc_raw = s2_r[1];
  assign vlo    = s2_r[2];
  assign vhi    = s2_r[3];
  // Edges armed once the synchronisers hold the pin level
  assign primed = (prime_r == 2'h3);
  assign rise   = primed && cmd && !cmd_d_r;
  assign fall   = primed && !cmd && cmd_d_r;

  // ----------------------------------------
  // Over-current filter
  // ----------------------------------------
  logic [25:0] flt_r, flt_nxt;
  logic        oc_r, oc_nxt;

  always_comb begin
    flt_nxt = flt_r;
    oc_nxt  = oc_r;
    if (oc_raw == oc_r) begin
      flt_nxt = 26'h0000000;
    end else if (flt_r == 26'(FILTER_CYC - 1)) begin
      flt_nxt = 26'h0000000;
      oc_nxt  = oc_raw;
    end else begin
      flt_nxt = flt_r + 26'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flt_r <= 26'h0000000;
      oc_r  <= 1'b0;
    end else begin
      flt_r <= flt_nxt;
      oc_r  <= oc_nxt;
    end
  end

  // ----------------------------------------
  // Motor sequencer
  // ----------------------------------------
  lmc_pkg::lmc_state_t st_r, st_nxt;
  logic [25:0] tmr_r, tmr_nxt;
  logic [25:0] run_r, run_nxt;
  logic        dir_r, dir_nxt;
  logic        err_r, err_nxt;
  logic        stop_oc;

  assign stop_oc = (st_r == lmc_pkg::LMC_RUN) && oc_r && !rise && !fall;

  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_r;
    dir_nxt = dir_r;
    err_nxt = err_r;
    run_nxt = (st_r == lmc_pkg::LMC_IDLE || st_r == lmc_pkg::LMC_STALL) ? run_r
              : ((run_r == 26'h3FFFFFF) ? run_r : run_r + 26'h0000001);
    if (rise || fall) begin
      dir_nxt = rise;
      st_nxt  = lmc_pkg::LMC_BLANK;
      tmr_nxt = 26'h0000000;
      run_nxt = 26'h0000000;
      if (fall) begin
        err_nxt = 1'b0;
      end
    end else begin
      unique case (st_r)
        lmc_pkg::LMC_IDLE: begin
        end
        lmc_pkg::LMC_BLANK: begin
          if (tmr_r == 26'(BLANK_CYC - 1)) begin
            st_nxt = lmc_pkg::LMC_RUN;
          end else begin
            tmr_nxt = tmr_r + 26'h0000001;
          end
        end
        lmc_pkg::LMC_RUN: begin
          if (stop_oc) begin
            st_nxt = lmc_pkg::LMC_STALL;
            if (dir_r && run_r < 26'(CLOSE_LIMIT_CYC)) begin
              err_nxt = 1'b1;
            end
          end
        end
        lmc_pkg::LMC_STALL: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r  <= lmc_pkg::LMC_IDLE;
      tmr_r <= 26'h0000000;
      run_r <= 26'h0000000;
      dir_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      tmr_r <= tmr_nxt;
      run_r <= run_nxt;
      dir_r <= dir_nxt;
      err_r <= err_nxt;
    end
  end

  // ----------------------------------------
  // PWM and outputs
  // ----------------------------------------
  lmc_pwm_if pif ();
  logic on;

  assign on            = (st_r == lmc_pkg::LMC_BLANK) || (st_r == lmc_pkg::LMC_RUN);
  assign pif.enable    = on;
  assign pif.volt_low  = vlo;
  assign pif.volt_high = vhi;

  lmc_pwm u_pwm (
    .clk   (clk),
    .rst_n (rst_n),
    .pif   (pif)
  );

  assign bridge_open     = pif.pwm && on && !dir_r;
  assign bridge_close    = pif.pwm && on && dir_r;
  assign error_out       = err_r;
  assign motor_on        = on;
  assign direction_close = dir_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_start;
    rise || fall;
  endsequence

  a_rise_close: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> dir_r && st_r == lmc_pkg::LMC_BLANK) else $error("rise did not start close");
  a_fall_open: assert property (@(posedge clk) disable iff (!rst_n)
    fall |=> !dir_r && !err_r) else $error("fall did not open or clear");
  a_blank_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_start |=> st_r == lmc_pkg::LMC_BLANK && tmr_r == 26'h0000000)
    else $error("blanking not restarted");
  a_oc_stop: assert property (@(posedge clk) disable iff (!rst_n)
    stop_oc |=> !on && !bridge_open && !bridge_close) else $error("overcurrent did not stop");
  a_blank_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == lmc_pkg::LMC_BLANK && oc_r && tmr_r != 26'(BLANK_CYC - 1) |=> on)
    else $error("stop during blanking");
  a_stall_keep: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == lmc_pkg::LMC_STALL && !rise && !fall |=> st_r == lmc_pkg::LMC_STALL)
    else $error("restart without edge");
  a_err_set: assert property (@(posedge clk) disable iff (!rst_n)
    stop_oc && dir_r && run_r < 26'(CLOSE_LIMIT_CYC) |=> err_r) else $error("error not set");
  a_err_hold: assert property (@(posedge clk) disable iff (!rst_n)
    err_r && !fall |=> err_r) else $error("error dropped early");
  a_filter_glitch: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(oc_r) |-> $past(oc_raw)) else $error("filter passed glitch");
  a_reverse: assert property (@(posedge clk) disable iff (!rst_n)
    on && fall |=> on && !dir_r) else $error("no reversal");
endmodule : lmc_lock_motor_controller

// ==== tb/lmc_motor_model.sv ====
`timescale 1ns/1ps
module lmc_motor_model #(
  parameter int unsigned INRUSH_CYC = 30
) (
  // Clock
  input  wire logic clk,
  // From bridge
  input  wire logic motor_on,
  // Bench controls
  input  wire logic jam,
  input  wire logic spike,
  input  wire logic batt_low,
  input  wire logic batt_high,
  // To controller
  output logic      overcurrent_compare,
  output logic      volt_low,
  output logic      volt_high
);
  int unsigned run_cyc = 0;
  initial overcurrent_compare = 1'b0;
  initial volt_low = 1'b0;
  initial volt_high = 1'b0;
  // Inrush, stall at end stop, current drops when off
  always @(posedge clk) begin
    run_cyc <= motor_on ? run_cyc + 1 : 0;
    overcurrent_compare <= (motor_on && (run_cyc < INRUSH_CYC || jam)) || spike;
    volt_low <= batt_low;
    volt_high <= batt_high;
  end
endmodule : lmc_motor_model

// ==== tb/lmc_lock_motor_controller_tb_top.sv ====
`timescale 1ns/1ps
module lmc_lock_motor_controller_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd = 1'b0;
  logic jam = 1'b0;
  logic spike = 1'b0;
  logic batt_low = 1'b0;
  logic batt_high = 1'b0;
  logic oc, vlo, vhi, br_open, br_close, err, mon, dir;
  int   err_total = 0;
  int   checks_done = 0;
  int   cyc = 0;
  logic [31:0] cnt, cnt_open, prev;
  // ----------------------------------------
  // Design and motor
  // ----------------------------------------
  lmc_lock_motor_controller #(.BLANK_CYC(50), .CLOSE_LIMIT_CYC(200), .FILTER_CYC(4)) u_lmc_lock_motor_controller (
    .clk(clk), .rst_n(rst_n), .lock_command_input(cmd), .overcurrent_compare(oc),
    .volt_low(vlo), .volt_high(vhi), .bridge_open(br_open), .bridge_close(br_close),
    .error_out(err), .motor_on(mon), .direction_close(dir));
  lmc_motor_model u_lmc_motor_model (
    .clk(clk), .motor_on(mon), .jam(jam), .spike(spike), .batt_low(batt_low),
    .batt_high(batt_high), .overcurrent_compare(oc), .volt_low(vlo), .volt_high(vhi));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic measure();
    cnt = 32'h0;
    cnt_open = 32'h0;
    repeat (256) begin
      @(posedge clk);
      #1;
      cnt = cnt + {31'h0, br_close};
      cnt_open = cnt_open + {31'h0, br_open};
    end
  endtask : measure
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_close_normal();
    @(posedge clk) cmd <= 1'b1;
    step(6);
    chk(mon, 1'b1);
    chk(dir, 1'b1);
    step(20);
    chk(mon, 1'b1);
    step(224);
    @(posedge clk) spike <= 1'b1;
    step(1);
    @(posedge clk) spike <= 1'b0;
    step(10);
    chk(mon, 1'b1);
    @(posedge clk) jam <= 1'b1;
    step(12);
    chk(mon, 1'b0);
    chk(err, 1'b0);
    @(posedge clk) jam <= 1'b0;
    step(100);
    chk(mon, 1'b0);
  endtask : s_close_normal
  task automatic s_reverse();
    @(posedge clk) cmd <= 1'b0;
    step(6);
    chk({mon, dir}, 2'h2);
    step(74);
    measure();
    chk(cnt_open, 32'h80);
    chk(cnt, 32'h0);
    @(posedge clk) cmd <= 1'b1;
    step(6);
    chk({mon, dir}, 2'h3);
    @(posedge clk) cmd <= 1'b0;
    step(6);
    chk({mon, dir}, 2'h2);
    @(posedge clk) jam <= 1'b1;
    step(70);
    chk(mon, 1'b0);
    @(posedge clk) jam <= 1'b0;
  endtask : s_reverse
  task automatic s_error();
    @(posedge clk) begin
      cmd <= 1'b1;
      jam <= 1'b1;
    end
    step(70);
    chk(mon, 1'b0);
    chk(err, 1'b1);
    @(posedge clk) jam <= 1'b0;
    step(100);
    chk(err, 1'b1);
    @(posedge clk) cmd <= 1'b0;
    step(6);
    chk({err, mon}, 2'h1);
    @(posedge clk) jam <= 1'b1;
    step(70);
    chk({err, mon}, 2'h0);
    @(posedge clk) jam <= 1'b0;
  endtask : s_error
  task automatic s_duty();
    @(posedge clk) cmd <= 1'b1;
    step(80);
    measure();
    chk(cnt, 32'h80);
    chk(br_open, 1'b0);
    @(posedge clk) batt_low <= 1'b1;
    step(5000);
    @(posedge clk) batt_low <= 1'b0;
    step(8);
    measure();
    prev = cnt;
    chk(prev > 32'h80, 1'b1);
    @(posedge clk) batt_high <= 1'b1;
    step(12500);
    @(posedge clk) batt_high <= 1'b0;
    step(8);
    measure();
    chk(cnt < prev, 1'b1);
  endtask : s_duty
  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    step(16);
    @(posedge clk) rst_n <= 1'b1;
    step(4);
    chk({mon, err, dir, br_open, br_close}, 5'h00);
    s_close_normal();
    s_reverse();
    s_error();
    s_duty();
    close_out();
  end
endmodule : lmc_lock_motor_controller_tb_top
